/* File: src/timer_pair_defines.svh */
`ifndef TIMER_PAIR_DEFINES_SVH
`define TIMER_PAIR_DEFINES_SVH
// Behaviour
// - All counting stops while the processor sleeps.
// - Wide mode flags on full 32-bit period match or gate falling edge.
// - Either condition sets pair flag bit 7; request only when enabled.
// - Pair interrupt request is forwarded only while enable bit 7 is set.
// - Holding register at 0x108, between low count and high count.
// - Low control: on 15, idle 13, gate 6, prescale 5:4, wide 3, clk 1.
// - Second pair behaves exactly like the first apart from listed points.
// - Second pair produces no converter trigger on its match.
// - Second pair count is not offered as a capture/compare time base.
// - Second pair wide mode: low timer is low word, high is high word.
// - Wide mode ignores the high control register entirely.
// - Wide mode uses only the low timer's clock and gate input.
// - Second pair wide mode uses its high flag and high enable bit.
// - Wide timer counts each prescaler tick up to period, then restarts at zero.
// - Reading the low count latches the high count into the hold word.
// - Write hold first; in wide mode the next low count write moves hold to high count.
// - Prescale select divides the input clock by 1, 8, 64 or 256.

// =========================================================================
// Register indices; the APB byte address is four times the index.
`define IDX_A_CNT_LO 10'h106
`define IDX_A_HOLD 10'h108
`define IDX_A_CNT_HI 10'h10A
`define IDX_A_PER_LO 10'h10C
`define IDX_A_PER_HI 10'h10E
`define IDX_A_CTL_LO 10'h110
`define IDX_A_CTL_HI 10'h112
`define IDX_B_CNT_LO 10'h114
`define IDX_B_HOLD 10'h116
`define IDX_B_CNT_HI 10'h118
`define IDX_B_PER_LO 10'h11A
`define IDX_B_PER_HI 10'h11C
`define IDX_B_CTL_LO 10'h11E
`define IDX_B_CTL_HI 10'h120
`define IDX_IRQ_FLAG 10'h084
`define IDX_IRQ_EN 10'h08C
// Index span of one pair's seven registers.
`define PAIR_SPAN 10'h00E

// =========================================================================
// Control and interrupt field positions.
`define BIT_ON 15
`define BIT_IDLE_STOP 13
`define BIT_GATE 6
`define BIT_PRESC_HI 5
`define BIT_PRESC_LO 4
`define BIT_WIDE 3
`define BIT_CLK_SRC 1
`define BIT_IRQ_A 7
`define BIT_IRQ_B 12
// Writable bits of the low and high control registers.
`define CTL_LO_MASK 16'hA07A
`define CTL_HI_MASK 16'hA072

// =========================================================================
// Reset values.
`define RST_COUNT 16'h0000
`define RST_PERIOD 16'hFFFF
`define RST_CONTROL 16'h0000

// =========================================================================
// Prescaler terminal counts for divide by 1, 8, 64 and 256.
`define PRESC_LIM_1 8'h00
`define PRESC_LIM_8 8'h07
`define PRESC_LIM_64 8'h3F
`define PRESC_LIM_256 8'hFF
`endif

/* File: src/timer_pair_pkg.sv */
// =========================================================================
// Types shared by the timer pair block.
package timer_pair_pkg;
  typedef logic [15:0] word_type;
  typedef enum logic [3:0] {
    k_cnt_lo, k_hold, k_cnt_hi, k_per_lo, k_per_hi, k_ctl_lo, k_ctl_hi,
    k_irq_flag, k_irq_en
  } reg_kind_type;
  typedef struct packed {
    logic hit;
    logic pair;
    reg_kind_type kind;
  } reg_sel_type;
endpackage : timer_pair_pkg

/* File: src/presc_if.sv */
`timescale 1ns/1ps
// =========================================================================
// Link between a timer and its prescaler.
interface presc_if;
  logic clear;
  logic run;
  logic tick_in;
  logic [1:0] select;
  logic tick_out;
  modport ctrl (output clear, run, tick_in, select, input tick_out);
  modport presc (input clear, run, tick_in, select, output tick_out);
endinterface : presc_if

/* File: src/prescale_divider.sv */
`timescale 1ns/1ps
`include "timer_pair_defines.svh"
// =========================================================================
// Prescaler: passes one input tick out of every 1, 8, 64 or 256.
module prescale_divider
  import timer_pair_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  presc_if.presc pif // Prescaler link.
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] limit;

  // Maps the select field to its terminal count.
  function automatic logic [7:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'h0: div_limit = `PRESC_LIM_1;
      2'h1: div_limit = `PRESC_LIM_8;
      2'h2: div_limit = `PRESC_LIM_64;
      default: div_limit = `PRESC_LIM_256;
    endcase
  endfunction : div_limit

  // The output tick comes on the input tick that reaches the limit.
  assign limit = div_limit(pif.select);
  assign pif.tick_out = pif.run & pif.tick_in & (cnt_ff == limit);

  // A clear wins over counting so a count write restarts the division.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (pif.clear) begin
      nxt_cnt = 8'h00;
    end else if (pif.run && pif.tick_in) begin
      nxt_cnt = (cnt_ff == limit) ? 8'h00 : cnt_ff + 8'h01;
    end
  end

  // Registers the prescale count.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  a_presc_wrap: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    pif.tick_out |=> cnt_ff == 8'h00)
    else $error("Prescaler did not restart after its output tick.");

  a_presc_div8: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    pif.tick_out && pif.select == 2'h1 |-> cnt_ff == 8'h07)
    else $error("Divide by eight tick at wrong count.");
endmodule : prescale_divider

/* File: src/timer_pair_block.sv */
`timescale 1ns/1ps
`include "timer_pair_defines.svh"
// =========================================================================
// Two general purpose timer pairs behind an APB slave.
module timer_pair_block
  import timer_pair_pkg::*;
(
  input wire logic ref_clk, // 40 MHz system clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic sleep_mode, // Processor sleeps.
  input wire logic idle_mode, // Processor idles.
  input wire logic [3:0] external_clock_gate_input, // A lo, A hi, B lo, B hi.
  output logic irq_pair_a, // First pair interrupt request.
  output logic irq_pair_b, // Second pair interrupt request.
  output logic adc_trigger, // Converter trigger pulse, first pair only.
  output logic [15:0] timebase_low, // First pair low count for capture.
  output logic [15:0] timebase_high // First pair high count for capture.
);
  word_type cnt_ff [4];
  word_type nxt_cnt [4];
  word_type per_ff [4];
  word_type nxt_per [4];
  word_type ctl_ff [4];
  word_type nxt_ctl [4];
  word_type eff_ctl [4];
  word_type hold_ff [2];
  word_type nxt_hold [2];
  word_type rd_word;
  word_type wdata;
  logic [1:0] flag_ff, nxt_flag, en_ff, nxt_en;
  logic [1:0] sync_tick_ff, nxt_sync_tick;
  logic [1:0] wide, step_lo, match_ev, gate_ev;
  logic [3:0] ext_ff, run, rise, fall, tick_in, tick_out, clr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic irq_a_ff, irq_b_ff, trig_ff;
  logic setup, wr;
  reg_sel_type sel;

  // Decodes a word index into pair and register kind.
  function automatic reg_sel_type reg_decode(input logic [9:0] idx);
    reg_sel_type s;
    logic [9:0] off_a;
    logic [9:0] off_b;
    off_a = idx - `IDX_A_CNT_LO;
    off_b = idx - `IDX_B_CNT_LO;
    s.hit = 1'b1;
    s.pair = 1'b0;
    s.kind = k_irq_flag;
    if (idx == `IDX_IRQ_EN) begin
      s.kind = k_irq_en;
    end else if (idx == `IDX_IRQ_FLAG) begin
      s.kind = k_irq_flag;
    end else if (!off_a[0] && off_a <= `PAIR_SPAN - 10'h002) begin
      s.kind = reg_kind_type'({1'b0, off_a[3:1]});
    end else if (!off_b[0] && off_b <= `PAIR_SPAN - 10'h002) begin
      s.pair = 1'b1;
      s.kind = reg_kind_type'({1'b0, off_b[3:1]});
    end else begin
      s.hit = 1'b0;
    end
    return s;
  endfunction : reg_decode

  // =========================================================================
  // APB slave: data captured in setup, zero-wait access phase.
  assign sel = reg_decode(paddr[11:2]);
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & sel.hit;
  assign wdata = pwdata[15:0];
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~sel.hit;
  assign prdata = prdata_ff;
  assign irq_pair_a = irq_a_ff;
  assign irq_pair_b = irq_b_ff;
  assign adc_trigger = trig_ff;
  assign timebase_low = cnt_ff[0];
  assign timebase_high = cnt_ff[1];

  // Read multiplexer for the addressed register.
  always_comb begin
    rd_word = 16'h0000;
    case (sel.kind)
      k_cnt_lo: rd_word = cnt_ff[{sel.pair, 1'b0}];
      k_hold: rd_word = hold_ff[sel.pair];
      k_cnt_hi: rd_word = cnt_ff[{sel.pair, 1'b1}];
      k_per_lo: rd_word = per_ff[{sel.pair, 1'b0}];
      k_per_hi: rd_word = per_ff[{sel.pair, 1'b1}];
      k_ctl_lo: rd_word = ctl_ff[{sel.pair, 1'b0}];
      k_ctl_hi: rd_word = ctl_ff[{sel.pair, 1'b1}];
      k_irq_flag: begin
        rd_word[`BIT_IRQ_A] = flag_ff[0];
        rd_word[`BIT_IRQ_B] = flag_ff[1];
      end
      k_irq_en: begin
        rd_word[`BIT_IRQ_A] = en_ff[0];
        rd_word[`BIT_IRQ_B] = en_ff[1];
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // =========================================================================
  // Run, tick and event detection for each timer and pair.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      wide[p] = ctl_ff[2*p][`BIT_WIDE];
      eff_ctl[2*p] = ctl_ff[2*p];
      // The high timer takes its setup from the low one in wide mode.
      eff_ctl[2*p+1] = wide[p] ? ctl_ff[2*p] : ctl_ff[2*p+1];
    end
    for (int t = 0; t < 4; t++) begin
      run[t] = eff_ctl[t][`BIT_ON] & ~sleep_mode
        & ~(idle_mode & eff_ctl[t][`BIT_IDLE_STOP]);
      rise[t] = external_clock_gate_input[t] & ~ext_ff[t];
      fall[t] = ~external_clock_gate_input[t] & ext_ff[t];
      tick_in[t] = eff_ctl[t][`BIT_CLK_SRC] ? rise[t]
        : (~eff_ctl[t][`BIT_GATE] | external_clock_gate_input[t]);
      clr[t] = ~eff_ctl[t][`BIT_ON];
    end
    for (int p = 0; p < 2; p++) begin
      // Count writes restart the prescaler that feeds the written count.
      if (wr && sel.pair == p[0] && sel.kind == k_cnt_lo) begin
        clr[2*p] = 1'b1;
      end
      if (wr && sel.pair == p[0] && sel.kind == k_cnt_hi) begin
        clr[2*p+1] = 1'b1;
        clr[2*p] = clr[2*p] | wide[p];
      end
      step_lo[p] = sync_tick_ff[p] & run[2*p];
      if (wide[p]) begin
        match_ev[p] = step_lo[p]
          && {cnt_ff[2*p+1], cnt_ff[2*p]} == {per_ff[2*p+1], per_ff[2*p]};
        // Only the low timer's input gates a wide pair.
        gate_ev[p] = run[2*p] & ~eff_ctl[2*p][`BIT_CLK_SRC]
          & eff_ctl[2*p][`BIT_GATE] & fall[2*p];
      end else begin
        match_ev[p] = tick_out[2*p+1] && cnt_ff[2*p+1] == per_ff[2*p+1];
        gate_ev[p] = run[2*p+1] & ~eff_ctl[2*p+1][`BIT_CLK_SRC]
          & eff_ctl[2*p+1][`BIT_GATE] & fall[2*p+1];
      end
    end
  end

  // =========================================================================
  // One prescaler per timer.
  presc_if pif [4] ();
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_presc
      assign pif[g].clear = clr[g];
      assign pif[g].run = run[g];
      assign pif[g].tick_in = tick_in[g];
      assign pif[g].select = eff_ctl[g][`BIT_PRESC_HI:`BIT_PRESC_LO];
      assign tick_out[g] = pif[g].tick_out;
      prescale_divider u_div (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pif(pif[g])
      );
    end
  endgenerate

  // =========================================================================
  // Next state of counts and registers; bus writes win over counting.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_per = per_ff;
    nxt_ctl = ctl_ff;
    nxt_hold = hold_ff;
    nxt_flag = flag_ff;
    nxt_en = en_ff;
    nxt_prdata = prdata_ff;
    // The low timer's prescaler output is retimed by one flop.
    nxt_sync_tick = {tick_out[2], tick_out[0]};
    for (int p = 0; p < 2; p++) begin
      if (wide[p]) begin
        if (step_lo[p]) begin
          if (match_ev[p]) begin
            nxt_cnt[2*p] = 16'h0000;
            nxt_cnt[2*p+1] = 16'h0000;
          end else begin
            {nxt_cnt[2*p+1], nxt_cnt[2*p]} =
              {cnt_ff[2*p+1], cnt_ff[2*p]} + 32'h0000_0001;
          end
        end
      end else begin
        if (step_lo[p]) begin
          nxt_cnt[2*p] = (cnt_ff[2*p] == per_ff[2*p]) ? 16'h0000
            : cnt_ff[2*p] + 16'h0001;
        end
        if (tick_out[2*p+1]) begin
          nxt_cnt[2*p+1] = match_ev[p] ? 16'h0000
            : cnt_ff[2*p+1] + 16'h0001;
        end
      end
    end
    if (setup && !pwrite && sel.hit) begin
      nxt_prdata = {16'h0000, rd_word};
      if (sel.kind == k_cnt_lo) begin
        nxt_hold[sel.pair] = cnt_ff[{sel.pair, 1'b1}];
      end
    end
    if (wr) begin
      case (sel.kind)
        k_cnt_lo: begin
          nxt_cnt[{sel.pair, 1'b0}] = wdata;
          if (wide[sel.pair]) begin
            nxt_cnt[{sel.pair, 1'b1}] = hold_ff[sel.pair];
          end
        end
        k_hold: nxt_hold[sel.pair] = wdata;
        k_cnt_hi: nxt_cnt[{sel.pair, 1'b1}] = wdata;
        k_per_lo: nxt_per[{sel.pair, 1'b0}] = wdata;
        k_per_hi: nxt_per[{sel.pair, 1'b1}] = wdata;
        k_ctl_lo: nxt_ctl[{sel.pair, 1'b0}] = wdata & `CTL_LO_MASK;
        k_ctl_hi: nxt_ctl[{sel.pair, 1'b1}] = wdata & `CTL_HI_MASK;
        k_irq_flag: nxt_flag = {wdata[`BIT_IRQ_B], wdata[`BIT_IRQ_A]};
        k_irq_en: nxt_en = {wdata[`BIT_IRQ_B], wdata[`BIT_IRQ_A]};
        default: nxt_en = en_ff;
      endcase
    end
    // Event pulses set the flags and win over a clearing write.
    nxt_flag = nxt_flag | match_ev | gate_ev;
  end

  // Registers all block state.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int t = 0; t < 4; t++) begin
        cnt_ff[t] <= `RST_COUNT;
        per_ff[t] <= `RST_PERIOD;
        ctl_ff[t] <= `RST_CONTROL;
      end
      hold_ff[0] <= `RST_COUNT;
      hold_ff[1] <= `RST_COUNT;
      flag_ff <= 2'h0;
      en_ff <= 2'h0;
      sync_tick_ff <= 2'h0;
      ext_ff <= 4'h0;
      prdata_ff <= 32'h0000_0000;
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
      trig_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      per_ff <= nxt_per;
      ctl_ff <= nxt_ctl;
      hold_ff <= nxt_hold;
      flag_ff <= nxt_flag;
      en_ff <= nxt_en;
      sync_tick_ff <= nxt_sync_tick;
      ext_ff <= external_clock_gate_input;
      prdata_ff <= nxt_prdata;
      irq_a_ff <= nxt_flag[0] & nxt_en[0];
      irq_b_ff <= nxt_flag[1] & nxt_en[1];
      trig_ff <= match_ev[0];
    end
  end

  // =========================================================================
  // Checks on the timer behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_sleep_halts_count: assert property (
    sleep_mode && !wr |=> $stable(cnt_ff[0]) && $stable(cnt_ff[3]))
    else $error("Count moved while asleep.");

  a_match_sets_flag: assert property (
    match_ev[0] |=> flag_ff[0])
    else $error("Period match did not set the first pair flag.");

  a_gate_sets_flag: assert property (
    gate_ev[1] |=> flag_ff[1] ##0 $past(gate_ev[1]))
    else $error("Gate falling edge did not set the second pair flag.");

  a_flag_sticky: assert property (
    flag_ff[0] && !(wr && sel.kind == k_irq_flag) |=> flag_ff[0])
    else $error("Pair flag cleared without a software write.");

  a_irq_enable_gate: assert property (
    irq_pair_a == (flag_ff[0] && en_ff[0]))
    else $error("Interrupt request does not follow flag and enable.");

  a_hold_latch_read: assert property (
    setup && !pwrite && sel.hit && sel.kind == k_cnt_lo && !sel.pair
    |=> hold_ff[0] == $past(cnt_ff[1]))
    else $error("High count not latched on low count read.");

  a_hold_transfer: assert property (
    wr && sel.kind == k_cnt_lo && !sel.pair && wide[0]
    |=> cnt_ff[1] == $past(hold_ff[0]) && cnt_ff[0] == $past(wdata))
    else $error("Held word not moved into high count.");

  a_wide_wraps_zero: assert property (
    wide[0] && match_ev[0] && !wr |=> cnt_ff[0] == 16'h0000
    && cnt_ff[1] == 16'h0000)
    else $error("Wide count did not restart at zero.");

  a_wide_high_word: assert property (
    wide[1] && !wr && cnt_ff[2] != 16'hFFFF && !match_ev[1]
    |=> $stable(cnt_ff[3]))
    else $error("High word moved without a low word carry.");

  a_no_trigger_b: assert property (
    !match_ev[0] |=> !adc_trigger)
    else $error("Converter trigger without a first pair match.");

  a_flag_from_pulse: assert property (
    $rose(flag_ff[1]) |-> $past(match_ev[1]) || $past(gate_ev[1])
    || ($past(wr) && $past(sel.kind) == k_irq_flag))
    else $error("Flag rose without an event or write.");
endmodule : timer_pair_block

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "timer_pair_defines.svh"
// =====================================================================
// Self-checking bench for the timer pair block.
module tb
  import timer_pair_pkg::*;
;
  logic ref_clk, reset_n, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sleep_mode, idle_mode, irq_pair_a, irq_pair_b;
  logic adc_trigger;
  logic [3:0] external_clock_gate_input;
  word_type timebase_low, timebase_high;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int adc_count = 0;
  int adc_last = 0;
  int adc_prev = 0;

  timer_pair_block i_timer_pair_block (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode),
    .external_clock_gate_input(external_clock_gate_input),
    .irq_pair_a(irq_pair_a), .irq_pair_b(irq_pair_b),
    .adc_trigger(adc_trigger), .timebase_low(timebase_low),
    .timebase_high(timebase_high));

  // The clock toggles every half period of 12.5 ns.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts cycles, logs converter pulses and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (adc_trigger === 1'b1) begin
      adc_count <= adc_count + 1;
      adc_prev <= adc_last;
      adc_last <= cyc;
    end
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Compares a seen value with the expected one.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; waits for pready, then releases the bus.
  // The slave answers in the first access cycle, so one wait is expected.
  task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 32'h0000_0001);
  endtask : apb

  task wr(input logic [9:0] idx, input word_type v);
    apb(1'b1, idx, {16'h0000, v});
  endtask : wr

  task rchk(input logic [9:0] idx, input word_type exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, {16'h0000, exp});
  endtask : rchk

  task wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cyc

  // Reset values, writable control bits and an unmapped address.
  task test_reset();
    rchk(`IDX_A_CTL_LO, 16'h0000);
    rchk(`IDX_A_CTL_HI, 16'h0000);
    rchk(`IDX_A_PER_LO, 16'hFFFF);
    rchk(`IDX_A_PER_HI, 16'hFFFF);
    rchk(`IDX_B_PER_HI, 16'hFFFF);
    rchk(`IDX_B_CTL_LO, 16'h0000);
    apb(1'b0, 10'h000, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    wr(`IDX_A_CTL_LO, 16'hFFFF);
    rchk(`IDX_A_CTL_LO, `CTL_LO_MASK);
    wr(`IDX_A_CTL_LO, 16'h0000);
    $display("test_reset done");
  endtask : test_reset

  // Coherent write through the hold word, then coherent read.
  task test_coherent();
    wr(`IDX_A_CTL_LO, 16'h0008);
    wr(`IDX_A_HOLD, 16'h1234);
    wr(`IDX_A_CNT_LO, 16'h5678);
    rchk(`IDX_A_CNT_HI, 16'h1234);
    check({16'h0000, timebase_high}, 32'h0000_1234);
    wr(`IDX_A_HOLD, 16'hAAAA);
    rchk(`IDX_A_CNT_LO, 16'h5678);
    rchk(`IDX_A_HOLD, 16'h1234);
    wr(`IDX_A_HOLD, 16'h0000);
    wr(`IDX_A_CNT_LO, 16'h0000);
    wr(`IDX_A_CTL_LO, 16'h0000);
    $display("test_coherent done");
  endtask : test_coherent

  // Wide mode match, sticky flag, enable gating; pair B side effects.
  task test_wide(input logic pb);
    logic [9:0] b;
    word_type fb, tb0;
    int adc0;
    b = pb ? `IDX_B_CNT_LO : `IDX_A_CNT_LO;
    fb = pb ? 16'h1000 : 16'h0080;
    tb0 = timebase_low;
    adc0 = adc_count;
    wr(b + 10'h006, 16'h0001);
    wr(b + 10'h008, 16'h0000);
    wr(b + 10'h00A, 16'h8008);
    wait_cyc(20);
    wr(b + 10'h00A, 16'h0000);
    rchk(`IDX_IRQ_FLAG, fb);
    check({31'h0, pb ? irq_pair_b : irq_pair_a}, 32'h0);
    wr(`IDX_IRQ_EN, fb);
    wait_cyc(2);
    check({31'h0, pb ? irq_pair_b : irq_pair_a}, 32'h1);
    wait_cyc(30);
    rchk(`IDX_IRQ_FLAG, fb);
    if (pb) begin
      check(adc_count, adc0);
      check({16'h0000, timebase_low}, {16'h0000, tb0});
    end
    wr(`IDX_IRQ_FLAG, 16'h0000);
    wr(`IDX_IRQ_EN, 16'h0000);
    rchk(`IDX_IRQ_FLAG, 16'h0000);
    wr(b + 10'h006, 16'hFFFF);
    wr(b + 10'h008, 16'hFFFF);
    $display("test_wide done");
  endtask : test_wide

  // Match spacing for each prescale; high control is set but ignored.
  task test_prescale();
    int div[4] = '{1, 8, 64, 256};
    int n, c0, s;
    wr(`IDX_A_PER_LO, 16'h0001);
    wr(`IDX_A_PER_HI, 16'h0000);
    wr(`IDX_A_CTL_HI, 16'h8030);
    for (s = 0; s < 4; s++) begin
      wr(`IDX_A_CTL_LO, {8'h80, 2'b00, s[1:0], 4'h8});
      c0 = adc_count;
      n = 0;
      while (adc_count < c0 + 3 && n < 3000) begin
        @(posedge ref_clk);
        n++;
      end
      check(adc_last - adc_prev, 2 * div[s]);
      wr(`IDX_A_CTL_LO, 16'h0000);
    end
    wr(`IDX_A_CTL_HI, 16'h0000);
    wr(`IDX_A_PER_LO, 16'hFFFF);
    wr(`IDX_A_PER_HI, 16'hFFFF);
    wr(`IDX_IRQ_FLAG, 16'h0000);
    $display("test_prescale done");
  endtask : test_prescale

  // Sleep and idle halt counting; only the low gate input flags.
  task test_halt();
    word_type v;
    wr(`IDX_A_CTL_LO, 16'hA008);
    wait_cyc(5);
    sleep_mode <= 1'b1;
    wait_cyc(4);
    apb(1'b0, `IDX_A_CNT_LO, 32'h0000_0000);
    v = rd[15:0];
    wait_cyc(10);
    rchk(`IDX_A_CNT_LO, v);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    wait_cyc(4);
    apb(1'b0, `IDX_A_CNT_LO, 32'h0000_0000);
    v = rd[15:0];
    wait_cyc(10);
    rchk(`IDX_A_CNT_LO, v);
    idle_mode <= 1'b0;
    wr(`IDX_A_CTL_LO, 16'h0000);
    wr(`IDX_IRQ_FLAG, 16'h0000);
    wr(`IDX_A_CTL_HI, 16'h8040);
    wr(`IDX_A_CTL_LO, 16'h8048);
    external_clock_gate_input[1] <= 1'b1;
    wait_cyc(5);
    external_clock_gate_input[1] <= 1'b0;
    wait_cyc(5);
    rchk(`IDX_IRQ_FLAG, 16'h0000);
    external_clock_gate_input[0] <= 1'b1;
    wait_cyc(10);
    external_clock_gate_input[0] <= 1'b0;
    wait_cyc(5);
    rchk(`IDX_IRQ_FLAG, 16'h0080);
    wr(`IDX_A_CTL_LO, 16'h0000);
    wr(`IDX_IRQ_FLAG, 16'h0000);
    wr(`IDX_B_CTL_LO, 16'h8048);
    external_clock_gate_input[2] <= 1'b1;
    wait_cyc(10);
    external_clock_gate_input[2] <= 1'b0;
    wait_cyc(5);
    rchk(`IDX_IRQ_FLAG, 16'h1000);
    wr(`IDX_B_CTL_LO, 16'h0000);
    wr(`IDX_IRQ_FLAG, 16'h0000);
    $display("test_halt done");
  endtask : test_halt

  // Main sequence: reset for 20 cycles, then every scenario.
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sleep_mode = 1'b0;
    idle_mode = 1'b0;
    external_clock_gate_input = 4'h0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    test_reset();
    test_coherent();
    test_wide(1'b0);
    test_wide(1'b1);
    test_prescale();
    test_halt();
    print_verdict();
  end
endmodule : tb
